//--- tb_top.sv
// Bench for the link control core: host port, link speed, buffer.
// Assumes a host line model answers chirps; long counts are shortened.
`timescale 1ns/100ps
`include "uhl_defines.svh"
module tb_top;
    import uhl_pkg::*;
    logic core_clk, rst_b, bus_config_select, strobe_style_select, address_latch_style;
    logic chip_select_b, address_qualifier, read_or_dir, data_or_write_strobe;
    logic [7:0] ad_in, ad_out, s_addr;
    logic [15:0] data_in, data_out, reg_rdata, usb_wdata, buf_rdata, s_data;
    logic ad_oe, data_oe, write_locked, pullup_pin_to_dp, chirp_tx, hs_mode;
    logic pullup_connect_bit, pullup_connect_wr, buffer_flush_bit, resume_event;
    logic line_se0, bus_activity, chirp_handshake_ok, bus_reset_seen, suspend;
    logic usb_wr, ep_out_sel_empty_req, dma_rd, dma_done, buf_full, buf_empty;
    logic hs_host, seen;
    uhl_access_s host_access;
    uhl_cfg_s cfg;
    int fails = 0, cmp_count = 0, n;
    uhl_link_ctrl #(.IDLE_CYC(50), .SE0_MIN_CYC(10), .SE0_MAX_CYC(40)) dut (.*);
    uhl_usb_host_model u_host (.core_clk(core_clk), .hs_host(hs_host),
        .chirp_tx(chirp_tx), .chirp_handshake_ok(chirp_handshake_ok));
    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    task tick(input int k);
        repeat (k) @(posedge core_clk);
        #1;
    endtask
    task end_sim();
        $display("checks %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (e !== g)
        begin
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
            fails++;
        end
    endtask
    // Bounded wait for one output to reach a level
    task wait_lvl(input int sel, input logic v, input int lim);
        logic s;
        n = 0;
        s = !v;
        while (s !== v)
        begin
            case (sel)
                0: s = chirp_tx;
                1: s = hs_mode;
                2: s = suspend;
                3: s = buf_empty;
                default: s = write_locked;
            endcase
            if (s !== v) tick(1);
            n++;
            if (n > lim)
            begin
                chk("wait", 16'(sel), 16'hffff);
                end_sim();
            end
        end
    endtask
    // One host cycle with read/write strobes, noting the decoded pulse
    task host_acc(input logic wr, input logic [7:0] a, input logic [15:0] d);
        seen = 1'b0;
        ad_in = a;
        data_in = d;
        chip_select_b = 1'b0;
        if (wr) data_or_write_strobe = 1'b0;
        else read_or_dir = 1'b0;
        repeat (6)
        begin
            tick(1);
            if ((wr ? host_access.wr : host_access.rd) === 1'b1)
            begin
                seen = 1'b1;
                s_addr = host_access.addr;
                s_data = host_access.wdata;
            end
            if (!wr && data_oe === 1'b1) s_data = data_out;
        end
        chip_select_b = 1'b1;
        data_or_write_strobe = 1'b1;
        read_or_dir = 1'b1;
        tick(4);
    endtask
    task do_reset();
        rst_b = 1'b0;
        tick(12);
        rst_b = 1'b1;
        tick(6);
    endtask
    task to_hs();
        line_se0 = 1'b1;
        wait_lvl(1, 1'b1, 100);
        line_se0 = 1'b0;
        tick(1);
    endtask
    initial
    begin
        #900000;
        chk("timeout", 16'h0, 16'h1);
        end_sim();
    end
    initial
    begin
        {bus_config_select, strobe_style_select, address_latch_style} = 3'h7;
        {chip_select_b, read_or_dir, data_or_write_strobe} = 3'h7;
        {address_qualifier, pullup_connect_bit, pullup_connect_wr} = 3'h0;
        {buffer_flush_bit, resume_event, line_se0, usb_wr, dma_rd} = 5'h0;
        {ep_out_sel_empty_req, dma_done} = 2'h0;
        {ad_in, data_in, reg_rdata, usb_wdata} = 56'h0;
        bus_activity = 1'b1;
        hs_host = 1'b0;
        do_reset();
        chk("cfg", 16'h3, 16'(cfg));
        chk("pullup", 16'h0, 16'(pullup_pin_to_dp));
        chk("empty", 16'h1, 16'(buf_empty));
        bus_config_select = 1'b0;
        tick(5);
        chk("cfg_held", 16'h3, 16'(cfg));
        host_acc(1'b1, 8'h5a, 16'h1234);
        chk("wr", 16'h1, 16'(seen));
        chk("wr_addr", 16'h5a, 16'(s_addr));
        chk("wr_data", 16'h1234, s_data);
        reg_rdata = 16'hbeef;
        host_acc(1'b0, 8'h0c, 16'h0);
        chk("rd", 16'h1, 16'(seen));
        chk("rd_addr", 16'h0c, 16'(s_addr));
        chk("rd_data", 16'hbeef, s_data);
        pullup_connect_bit = 1'b1;
        pullup_connect_wr = 1'b1;
        tick(1);
        pullup_connect_wr = 1'b0;
        tick(3);
        chk("pullup_on", 16'h1, 16'(pullup_pin_to_dp));
        $display("test host_port done");
        tick(100);
        chk("fs_hold", 16'h0, 16'({hs_mode, chirp_tx}));
        bus_activity = 1'b0;
        line_se0 = 1'b1;
        wait_lvl(0, 1'b1, 60);
        tick(40);
        chk("fs_host", 16'h0, 16'(hs_mode));
        line_se0 = 1'b0;
        tick(10);
        hs_host = 1'b1;
        to_hs();
        chk("pullup_kept", 16'h1, 16'(pullup_pin_to_dp));
        line_se0 = 1'b1;
        wait_lvl(1, 1'b0, 200);
        chk("idle_len", 16'h1, 16'(n >= 45));
        wait_lvl(0, 1'b1, 30);
        chk("se0_len", 16'h1, 16'(n >= 8));
        wait_lvl(1, 1'b1, 30);
        line_se0 = 1'b0;
        wait_lvl(1, 1'b0, 200);
        wait_lvl(2, 1'b1, 10);
        $display("test link_speed done");
        resume_event = 1'b1;
        tick(1);
        resume_event = 1'b0;
        tick(3);
        chk("locked", 16'h1, 16'(write_locked));
        host_acc(1'b1, 8'h20, 16'h5555);
        chk("wr_blocked", 16'h0, 16'(seen));
        pullup_connect_bit = 1'b0;
        pullup_connect_wr = 1'b1;
        tick(1);
        pullup_connect_wr = 1'b0;
        tick(2);
        chk("pu_locked", 16'h1, 16'(pullup_pin_to_dp));
        host_acc(1'b1, 8'h20, `UHL_UNLOCK_CODE);
        wait_lvl(4, 1'b0, 10);
        host_acc(1'b1, 8'h20, 16'h5555);
        chk("wr_open", 16'h1, 16'(seen));
        $display("test write_lock done");
        usb_wr = 1'b1;
        usb_wdata = 16'h1111;
        tick(1);
        usb_wdata = 16'h2222;
        tick(1);
        usb_wr = 1'b0;
        tick(2);
        chk("held", 16'h0, 16'(buf_empty));
        chk("head", 16'h1111, buf_rdata);
        dma_rd = 1'b1;
        tick(1);
        dma_rd = 1'b0;
        tick(1);
        chk("pop", 16'h2222, buf_rdata);
        {buffer_flush_bit, ep_out_sel_empty_req} = 2'h3;
        tick(1);
        {buffer_flush_bit, ep_out_sel_empty_req} = 2'h0;
        wait_lvl(3, 1'b1, 3);
        n = 0;
        usb_wr = 1'b1;
        while (buf_full !== 1'b1 && n < 5000)
        begin
            usb_wdata = n[15:0];
            tick(1);
            n++;
        end
        usb_wr = 1'b0;
        chk("fill", 16'h1000, n[15:0]);
        dma_done = 1'b1;
        tick(1);
        dma_done = 1'b0;
        wait_lvl(3, 1'b1, 5);
        $display("test buffer done");
        {bus_config_select, strobe_style_select, address_latch_style} = 3'h0;
        do_reset();
        chk("cfg_split", 16'h4, 16'(cfg));
        ad_in = 8'h3c;
        address_qualifier = 1'b1;
        tick(3);
        address_qualifier = 1'b0;
        read_or_dir = 1'b0;
        host_acc(1'b1, 8'h77, 16'h0);
        chk("sp_addr", 16'h3c, 16'(s_addr));
        chk("sp_data", 16'h0077, s_data);
        $display("test split_config done");
        end_sim();
    end
endmodule // tb_top

//--- uhl_buf_ram.sv
// Shared endpoint buffer memory, one write and one read port.
// Assumes one clock; read data is registered.
`timescale 1ns/100ps
module uhl_buf_ram #(
    parameter int AW = 12,
    parameter int DW = 16
) (
    input wire logic core_clk,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [DW-1:0] wdata,
    input wire logic [AW-1:0] raddr,
    output logic [DW-1:0] rdata
);
    // Storage array
    logic [DW-1:0] mem [0:(1<<AW)-1];

    // Write and registered read
    always_ff @(posedge core_clk)
    begin
        if (we)
        begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule // uhl_buf_ram

//--- uhl_defines.svh
// Constants for the USB peripheral host-port and link control core.
// Assumes a 100 MHz core clock; times are given in their own units.
`ifndef UHL_DEFINES_SVH
`define UHL_DEFINES_SVH
// Clock rate in MHz
`define UHL_CLK_MHZ 100
// Bus idle time before HS falls back to FS, in microseconds
`define UHL_IDLE_US 3000
`define UHL_IDLE_CYC (`UHL_IDLE_US * `UHL_CLK_MHZ)
// SE0 window that marks a reset, microseconds
`define UHL_SE0_MIN_US 100
`define UHL_SE0_MAX_US 875
`define UHL_SE0_MIN_CYC (`UHL_SE0_MIN_US * `UHL_CLK_MHZ)
`define UHL_SE0_MAX_CYC (`UHL_SE0_MAX_US * `UHL_CLK_MHZ)
// Shared buffer size in bytes and word layout
`define UHL_BUF_BYTES 8192
`define UHL_BUF_AW 12
`define UHL_BUF_DW 16
// Unlock code for the write lock after resume (arbitrary value)
`define UHL_UNLOCK_CODE 16'haa37
// Reset value of the pull-up connect bit
`define UHL_PULLUP_RST 1'b0
`endif

//--- uhl_link_ctrl.sv
// Host port, link speed detection and shared buffer control.
// Assumes pins are asynchronous; serial front end and analog live outside.
// How it works
// - Config high: separate address bus, 16-bit data.
// - Config low: multiplexed bus, wide bus DMA.
// - Style high: separate read and write strobes.
// - Style low: direction plus data strobe.
// - Latch style low: qualifier latches address.
// - Latch style high: qualifier marks address/data.
// - Configuration taken from pins at power-up.
// - Buffer released after host read (multiplexed bus only) or DMA.
// - Flush bit empties selected OUT buffer.
// - One 8 kB buffer shared three ways.
// - Stay full-speed until bus reset seen.
// - Chirp during reset; HS only on handshake.
// - HS idle 3 ms: revert, check SE0.
// - SE0 100-875 us means reset, else suspend.
// - Front end uses 16-bit parallel path.
// - Protocol engine runs fully in hardware.
// - Pull-up connect bit routes pull-up pin.
// - Hardware reset clears pull-up; bus reset doesn't.
// - Writes blocked after resume until unlock.
`timescale 1ns/100ps
`include "uhl_defines.svh"
module uhl_link_ctrl #(
    parameter int IDLE_CYC = `UHL_IDLE_CYC,
    parameter int SE0_MIN_CYC = `UHL_SE0_MIN_CYC,
    parameter int SE0_MAX_CYC = `UHL_SE0_MAX_CYC,
    parameter int AW = `UHL_BUF_AW
) (
    input wire logic core_clk,
    input wire logic rst_b,
    // Configuration straps
    input wire logic bus_config_select,
    input wire logic strobe_style_select,
    input wire logic address_latch_style,
    // Host port pins
    input wire logic chip_select_b,
    input wire logic address_qualifier,
    input wire logic read_or_dir,
    input wire logic data_or_write_strobe,
    input wire logic [7:0] ad_in,
    output logic [7:0] ad_out,
    output logic ad_oe,
    input wire logic [15:0] data_in,
    output logic [15:0] data_out,
    output logic data_oe,
    // Decoded access toward the register set
    output uhl_pkg::uhl_access_s host_access,
    output uhl_pkg::uhl_cfg_s cfg,
    input wire logic [15:0] reg_rdata,
    // Control bits
    input wire logic pullup_connect_bit,
    input wire logic pullup_connect_wr,
    input wire logic buffer_flush_bit,
    input wire logic resume_event,
    output logic write_locked,
    output logic pullup_pin_to_dp,
    // Line state from the analog side
    input wire logic line_se0,
    input wire logic bus_activity,
    input wire logic chirp_handshake_ok,
    output logic chirp_tx,
    output logic hs_mode,
    output logic bus_reset_seen,
    output logic suspend,
    // Endpoint buffer traffic (protocol engine writes, host/DMA read)
    input wire logic usb_wr,
    input wire logic [15:0] usb_wdata,
    input wire logic ep_out_sel_empty_req,
    input wire logic dma_rd,
    input wire logic dma_done,
    output logic [15:0] buf_rdata,
    output logic buf_full,
    output logic buf_empty
);
    import uhl_pkg::*;

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [10:0] sync1_reg;
    logic [10:0] sync2_reg;
    logic [10:0] pins_raw;
    logic [7:0] ad_s_reg;
    logic [7:0] ad_s2_reg;
    logic [15:0] data_s_reg;
    logic [15:0] data_s2_reg;

    // Gather all single-bit pins
    always_comb
    begin
        pins_raw = {bus_config_select, strobe_style_select, address_latch_style,
                    chip_select_b, address_qualifier, read_or_dir,
                    data_or_write_strobe, line_se0, bus_activity,
                    chirp_handshake_ok, resume_event};
    end

    // Two flops on every pin
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            // Select and strobes start at their idle high level
            sync1_reg <= 11'h0b0;
            sync2_reg <= 11'h0b0;
            ad_s_reg <= 8'h00;
            ad_s2_reg <= 8'h00;
            data_s_reg <= 16'h0000;
            data_s2_reg <= 16'h0000;
        end
        else
        begin
            sync1_reg <= pins_raw;
            sync2_reg <= sync1_reg;
            ad_s_reg <= ad_in;
            ad_s2_reg <= ad_s_reg;
            data_s_reg <= data_in;
            data_s2_reg <= data_s_reg;
        end
    end

    logic cs_b_s, qual_s, rdir_s, wstb_s, se0_s, act_s, hsok_s, resume_s;
    assign cs_b_s = sync2_reg[7];
    assign qual_s = sync2_reg[6];
    assign rdir_s = sync2_reg[5];
    assign wstb_s = sync2_reg[4];
    assign se0_s = sync2_reg[3];
    assign act_s = sync2_reg[2];
    assign hsok_s = sync2_reg[1];
    assign resume_s = sync2_reg[0];

    // ----------------------------------------
    // Configuration capture
    // ----------------------------------------
    logic cfg_taken_reg, cfg_taken_next;
    logic [1:0] fill_reg, fill_next; // Edges since release, until straps are through sync
    uhl_cfg_s cfg_reg, cfg_next;

    // capture straps once, after the sync has filled
    always_comb
    begin
        cfg_next = cfg_reg;
        fill_next = (fill_reg == 2'h2) ? fill_reg : fill_reg + 2'h1;
        cfg_taken_next = cfg_taken_reg | (fill_reg == 2'h2);
        if (!cfg_taken_reg && fill_reg == 2'h2)
        begin
            cfg_next.split_bus = ~sync2_reg[10];
            cfg_next.rd_wr_strobes = sync2_reg[9];
            cfg_next.ale_level = sync2_reg[8];
        end
    end

    // Configuration register
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cfg_reg <= '0;
            cfg_taken_reg <= 1'b0;
            fill_reg <= 2'h0;
        end
        else
        begin
            cfg_reg <= cfg_next;
            cfg_taken_reg <= cfg_taken_next;
            fill_reg <= fill_next;
        end
    end
    assign cfg = cfg_reg;

    // ----------------------------------------
    // Host bus decode
    // ----------------------------------------
    logic rd_act, wr_act, wstb_d_reg, rd_d_reg;
    logic [7:0] addr_reg, addr_next;
    logic addr_phase;
    logic wr_now, rd_now;

    always_comb
    begin
        if (cfg_reg.rd_wr_strobes)
        begin
            rd_act = ~cs_b_s & ~rdir_s;
            wr_act = ~cs_b_s & ~wstb_s;
        end
        else
        begin
            rd_act = ~cs_b_s & ~wstb_s & rdir_s;
            wr_act = ~cs_b_s & ~wstb_s & ~rdir_s;
        end
    end

    always_comb
    begin
        addr_next = addr_reg;
        addr_phase = 1'b0;
        if (!cfg_reg.split_bus)
        begin
            addr_next = ad_s2_reg;
        end
        else if (cfg_reg.ale_level)
        begin
            addr_phase = qual_s;
            if (qual_s && wr_act)
            begin
                addr_next = ad_s2_reg;
            end
        end
        else if (qual_s)
        begin
            addr_next = ad_s2_reg;
        end
    end

    // One write pulse per strobe; address-phase cycles carry no data
    assign wr_now = wr_act & ~wstb_d_reg & ~addr_phase & ~write_locked;
    assign rd_now = rd_act & ~rd_d_reg & ~addr_phase;

    // Address and edge registers
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            addr_reg <= 8'h00;
            wstb_d_reg <= 1'b0;
            rd_d_reg <= 1'b0;
        end
        else
        begin
            addr_reg <= addr_next;
            wstb_d_reg <= wr_act;
            rd_d_reg <= rd_act;
        end
    end

    // Access record and read drive
    logic [15:0] rd_word;
    always_comb
    begin
        host_access.wr = wr_now;
        host_access.rd = rd_now;
        host_access.addr = addr_next;
        host_access.wdata = cfg_reg.split_bus ? {8'h00, ad_s2_reg} : data_s2_reg;
        rd_word = reg_rdata;
    end

    // Output drivers registered
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ad_out <= 8'h00;
            ad_oe <= 1'b0;
            data_out <= 16'h0000;
            data_oe <= 1'b0;
        end
        else
        begin
            ad_out <= rd_word[7:0];
            ad_oe <= rd_act & cfg_reg.split_bus & ~addr_phase;
            data_out <= rd_word;
            data_oe <= rd_act & ~cfg_reg.split_bus;
        end
    end

    // ----------------------------------------
    // Write lock and pull-up
    // ----------------------------------------
    logic lock_reg, lock_next, pu_reg, pu_next;

    // lock after resume, unlock by code
    always_comb
    begin
        lock_next = lock_reg;
        pu_next = pu_reg;
        if (resume_s)
        begin
            lock_next = 1'b1;
        end
        else if (lock_reg && wr_act && !wstb_d_reg &&
                 host_access.wdata == `UHL_UNLOCK_CODE)
        begin
            lock_next = 1'b0;
        end
        // pull-up bit write, ignored while locked
        if (pullup_connect_wr && !lock_reg)
        begin
            pu_next = pullup_connect_bit;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            lock_reg <= 1'b0;
            pu_reg <= `UHL_PULLUP_RST;
        end
        else
        begin
            lock_reg <= lock_next;
            pu_reg <= pu_next;
        end
    end
    assign write_locked = lock_reg;
    assign pullup_pin_to_dp = pu_reg;

    // ----------------------------------------
    // Speed detection
    // ----------------------------------------
    uhl_link_e st_reg, st_next;
    logic [31:0] cnt_reg, cnt_next;

    always_comb
    begin
        st_next = st_reg;
        cnt_next = cnt_reg + 32'd1;
        case (st_reg)
            UHL_FS:
            begin
                if (!se0_s)
                    cnt_next = '0;
                else if (cnt_reg >= 32'(SE0_MIN_CYC))
                begin
                    st_next = UHL_CHIRP;
                    cnt_next = '0;
                end
            end
            UHL_CHIRP:
            begin
                if (hsok_s)
                begin
                    st_next = UHL_HS;
                    cnt_next = '0;
                end
                else if (!se0_s)
                begin
                    st_next = UHL_FS;
                    cnt_next = '0;
                end
            end
            UHL_HS:
            begin
                if (act_s)
                    cnt_next = '0;
                else if (cnt_reg >= 32'(IDLE_CYC))
                begin
                    st_next = UHL_FS_CHECK;
                    cnt_next = '0;
                end
            end
            UHL_FS_CHECK:
            begin
                if (se0_s && cnt_reg >= 32'(SE0_MIN_CYC) &&
                    cnt_reg <= 32'(SE0_MAX_CYC))
                begin
                    st_next = UHL_CHIRP;
                    cnt_next = '0;
                end
                else if (!se0_s || cnt_reg > 32'(SE0_MAX_CYC))
                begin
                    st_next = UHL_SUSPEND;
                    cnt_next = '0;
                end
            end
            UHL_SUSPEND:
            begin
                cnt_next = '0;
                if (act_s || resume_s)
                    st_next = UHL_FS;
            end
            default:
            begin
                st_next = UHL_FS;
            end
        endcase
    end

    // Link state registers
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_reg <= UHL_FS;
            cnt_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
            cnt_reg <= cnt_next;
        end
    end
    assign chirp_tx = (st_reg == UHL_CHIRP);
    assign hs_mode = (st_reg == UHL_HS);
    assign bus_reset_seen = (st_next == UHL_CHIRP) && (st_reg != UHL_CHIRP);
    assign suspend = (st_reg == UHL_SUSPEND);

    // ----------------------------------------
    // Shared endpoint buffer
    // ----------------------------------------
    logic [AW-1:0] wp_reg, wp_next, rp_reg, rp_next;
    logic [AW:0] lvl_reg, lvl_next;
    logic host_pop, do_push, do_pop;

    // one memory for USB, host and DMA
    assign host_pop = rd_now & cfg_reg.split_bus & ~buf_empty;
    // engine pushes words, no firmware step
    assign do_push = usb_wr & ~buf_full;
    assign do_pop = (host_pop | dma_rd) & ~buf_empty;

    // release by host read (multiplexed bus only), DMA or flush
    always_comb
    begin
        wp_next = do_push ? wp_reg + 1'b1 : wp_reg;
        rp_next = do_pop ? rp_reg + 1'b1 : rp_reg;
        lvl_next = lvl_reg + {{AW{1'b0}}, do_push} - {{AW{1'b0}}, do_pop};
        if ((buffer_flush_bit && ep_out_sel_empty_req) || dma_done)
        begin
            rp_next = wp_next;
            lvl_next = '0;
        end
    end

    // Buffer pointers
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wp_reg <= '0;
            rp_reg <= '0;
            lvl_reg <= '0;
        end
        else
        begin
            wp_reg <= wp_next;
            rp_reg <= rp_next;
            lvl_reg <= lvl_next;
        end
    end
    assign buf_empty = (lvl_reg == '0);
    assign buf_full = lvl_reg[AW];

    // 16-bit words from the front end
    uhl_buf_ram #(.AW(AW), .DW(`UHL_BUF_DW)) u_ram (
        .core_clk(core_clk),
        .we(do_push),
        .waddr(wp_reg),
        .wdata(usb_wdata),
        .raddr(rp_next),
        .rdata(buf_rdata)
    );
endmodule // uhl_link_ctrl

//--- uhl_link_ctrl_checker.sv
// Port-level checks on the link control core.
// Assumes one clock domain and the shortened idle count handed on by bind.
`timescale 1ns/100ps
`include "uhl_defines.svh"
module uhl_link_ctrl_checker #(
    parameter int IDLE_CYC = 50
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire uhl_pkg::uhl_cfg_s cfg,
    input wire uhl_pkg::uhl_access_s host_access,
    input wire logic write_locked,
    input wire logic resume_event,
    input wire logic pullup_connect_bit,
    input wire logic pullup_connect_wr,
    input wire logic pullup_pin_to_dp,
    input wire logic hs_mode,
    input wire logic chirp_tx,
    input wire logic bus_activity,
    input wire logic bus_reset_seen,
    input wire logic buffer_flush_bit,
    input wire logic ep_out_sel_empty_req,
    input wire logic usb_wr,
    input wire logic buf_full,
    input wire logic buf_empty
);
    import uhl_pkg::*;
    logic [2:0] cap_cnt; // Cycles since reset, saturating
    int idle_cnt; // Quiet cycles spent in high speed
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    // ----------------------------------------
    // Helper counters
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cap_cnt <= 3'h0;
            idle_cnt <= 0;
        end
        else
        begin
            cap_cnt <= (cap_cnt == 3'h7) ? cap_cnt : cap_cnt + 3'h1;
            idle_cnt <= (hs_mode && !bus_activity) ? idle_cnt + 1 : 0;
        end
    end
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    chk_cfg_held: assert property (cap_cnt == 3'h7 |-> $stable(cfg))
        else $error("configuration changed while running");
    chk_wr_pulse: assert property (host_access.wr |=> !host_access.wr)
        else $error("write pulse longer than one cycle");
    chk_lock_gate: assert property (write_locked && pullup_connect_wr |=>
        $stable(pullup_pin_to_dp))
        else $error("control write passed while locked");
    chk_lock_set: assert property (resume_event |-> ##[1:3] write_locked)
        else $error("resume did not lock writes");
    chk_pullup_on: assert property (pullup_connect_wr && pullup_connect_bit |->
        ##[1:2] pullup_pin_to_dp)
        else $error("pull-up not routed");
    chk_pullup_keep: assert property (!pullup_connect_wr [*3] |=>
        $stable(pullup_pin_to_dp))
        else $error("pull-up changed without a write");
    chk_hs_chirp: assert property ($rose(hs_mode) |-> $past(chirp_tx))
        else $error("high speed entered without chirp");
    chk_hs_early: assert property ($fell(hs_mode) |->
        $past(idle_cnt) >= IDLE_CYC - 2)
        else $error("high speed left too early");
    chk_hs_late: assert property (idle_cnt <= IDLE_CYC + 8)
        else $error("high speed kept while idle");
    chk_chirp_fs: assert property ($rose(chirp_tx) |-> !hs_mode)
        else $error("chirp started in high speed");
    chk_reset_pulse: assert property (bus_reset_seen |=> !bus_reset_seen)
        else $error("bus reset flag longer than one cycle");
    chk_flush_empty: assert property (buffer_flush_bit && ep_out_sel_empty_req
        && !usb_wr |-> ##[1:3] buf_empty)
        else $error("flush left data");
    chk_flag_excl: assert property (!(buf_full && buf_empty))
        else $error("buffer full and empty together");
    cov_hs: cover property ($rose(hs_mode));
    cov_unlock: cover property ($fell(write_locked));
    cov_full: cover property ($rose(buf_full));
endmodule // uhl_link_ctrl_checker
bind uhl_link_ctrl uhl_link_ctrl_checker #(.IDLE_CYC(IDLE_CYC)) u_chk (.*);

//--- uhl_pkg.sv
// Types shared by the link control core.
// Assumes uhl_defines.svh is on the include path.
package uhl_pkg;
    // Captured host port configuration
    typedef struct packed {
        logic split_bus;      // Address/data multiplexed on the local bus
        logic rd_wr_strobes;  // Separate read and write strobes
        logic ale_level;      // Qualifier is an address/data level
    } uhl_cfg_s;
    // Speed detection states
    typedef enum logic [2:0] {
        UHL_FS, UHL_CHIRP, UHL_HS, UHL_FS_CHECK, UHL_SUSPEND
    } uhl_link_e;
    // Host bus cycle decoded from the pins
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [15:0] wdata;
    } uhl_access_s;
endpackage

//--- uhl_usb_host_model.sv
// Host controller side of the chirp handshake.
// Assumes the bench drives the line state itself.
`timescale 1ns/100ps
module uhl_usb_host_model #(
    parameter int HS_DLY = 4
) (
    input wire logic core_clk,
    input wire logic hs_host,
    input wire logic chirp_tx,
    output logic chirp_handshake_ok
);
    int cnt = 0; // Chirp length seen so far
    // answer chirps only as an HS host
    always @(posedge core_clk)
    begin
        cnt <= (chirp_tx && hs_host) ? cnt + 1 : 0;
        chirp_handshake_ok <= hs_host && chirp_tx && (cnt >= HS_DLY);
    end
endmodule // uhl_usb_host_model
